// *** canfm_defs.vh ***
// constants for the can bus fault mode controller
`ifndef CANFM_DEFS_VH
`define CANFM_DEFS_VH

// ****************************************
// apb register map (byte addresses)
// ****************************************
`define CANFM_CTRL_ADDR      12'h000
`define CANFM_STATUS_ADDR    12'h004
`define CANFM_IRQ_STAT_ADDR  12'h008
`define CANFM_IRQ_MASK_ADDR  12'h00c
`define CANFM_TIMEOUT_ADDR   12'h010

// ****************************************
// field positions
// ****************************************
`define CANFM_CTRL_LOWPWR_BIT   0
`define CANFM_EV_SHORT_BIT      0
`define CANFM_EV_HVCC_BIT       1
`define CANFM_EV_LVCC_BIT       2
`define CANFM_EV_CLEAR_BIT      3
`define CANFM_EV_WIDTH          4

// ****************************************
// reset values and timing
// ****************************************
`define CANFM_TIMEOUT_NS        32'd40000
`define CANFM_CLK_PERIOD_NS     32'd25
`define CANFM_TIMEOUT_CYCLES    (`CANFM_TIMEOUT_NS / `CANFM_CLK_PERIOD_NS)
`define CANFM_PULSE_DIFF        4'd4
`define CANFM_MATCH_COUNT       4'd4

`endif

// *** canfm_timeout.v ***
// restartable timeout counter for one monitored condition
`timescale 1ns/1ps

module canfm_timeout #(
    parameter WIDTH = 16
) (
    input  wire             i_sys_clk,
    input  wire             i_rst,
    input  wire             i_cond,
    input  wire [WIDTH-1:0] i_terminal,
    output wire             o_expired
);
    reg [WIDTH-1:0] count_reg;

    // restart whenever the condition drops before expiry
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            count_reg <= {WIDTH{1'b0}};
        end else if (!i_cond) begin
            count_reg <= {WIDTH{1'b0}};
        end else if (count_reg != i_terminal) begin
            count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    assign o_expired = i_cond && (count_reg == i_terminal);
endmodule

// *** canfm_ctrl.v ***
// fault mode controller: mutual short, canh to supply, canl to supply
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "canfm_defs.vh"

// Function
// - a dominant differential level held for a whole timeout declares a mutual short.
// - after the mutual short timeout the receiver reads canh single ended.
// - after the mutual short timeout the canl driver and low side termination go off.
// - when the short clears to recessive the low side termination returns, canl stays off, error low.
// - recessive held for a timeout after the short clears restores differential mode.
// - canh dominant held for a timeout declares a canh to supply fault.
// - on that fault reception moves to canl single ended; data in the timeout may be lost.
// - canh driver and high side termination go off, weak pulldown stays, transmit on canl.
// - canh below recovery level for a timeout turns canl off, canh and termination on, error low.
// - recessive held for a second timeout restores differential mode and releases error.
// - a canl to supply fault is flagged when canl and canh pulse counts differ by four.
// - during a canl to supply fault both receiver and driver stay differential.
// - four consecutive matching pulses on both wires clear the canl to supply flag.
// - timeout detection of the two short faults stays active in low power modes.
module canfm_ctrl #(
    parameter TO_WIDTH = 16
) (
    input  wire        i_sys_clk,
    input  wire        i_rst,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output wire [31:0] o_prdata,
    output wire        o_pready,
    output wire        o_pslverr,
    input  wire        i_diff_dominant,
    input  wire        i_diff_recessive,
    input  wire        i_canh_dominant,
    input  wire        i_canh_recovered,
    input  wire        i_canh_edge,
    input  wire        i_canl_edge,
    input  wire        i_canh_rx,
    input  wire        i_canl_rx,
    input  wire        i_diff_rx,
    input  wire        i_txd,
    output reg         o_rxd,
    output reg         o_canh_drive,
    output reg         o_canh_drive_en,
    output reg         o_canl_drive,
    output reg         o_canl_drive_en,
    output reg         o_high_side_termination_switch,
    output reg         o_low_side_termination_switch,
    output reg         o_rth_weak_pulldown,
    output reg         o_err_n,
    output wire        o_irq
);
    // ****************************************
    // states
    // ****************************************
    localparam ST_NORMAL     = 3'd0;
    localparam ST_SHORT      = 3'd1;
    localparam ST_SHORT_REC  = 3'd2;
    localparam ST_HVCC       = 3'd3;
    localparam ST_HVCC_WAIT  = 3'd4;
    localparam ST_HVCC_REC   = 3'd5;

    localparam RX_DIFF = 2'd0;
    localparam RX_CANH = 2'd1;
    localparam RX_CANL = 2'd2;

    // reset value cut to the timer width on purpose
    localparam [31:0]         TO_RESET_FULL = `CANFM_TIMEOUT_CYCLES;
    localparam [TO_WIDTH-1:0] TO_RESET      = TO_RESET_FULL[TO_WIDTH-1:0];

    reg [2:0]          state_reg;
    reg [2:0]          state_next;
    reg                lowpwr_reg;
    reg [TO_WIDTH-1:0] timeout_reg;
    reg [`CANFM_EV_WIDTH-1:0] irq_stat_reg;
    reg [`CANFM_EV_WIDTH-1:0] irq_mask_reg;
    reg [31:0]         prdata_reg;
    reg [3:0]          hcnt_reg;
    reg [3:0]          lcnt_reg;
    reg [3:0]          match_reg;
    reg                lvcc_fault_reg;

    // ****************************************
    // apb slave
    // ****************************************
    wire apb_acc = i_psel && i_penable;
    wire apb_wr  = apb_acc && i_pwrite;
    wire apb_rd  = apb_acc && !i_pwrite;
    // read data loads in setup so it stands at the access edge
    wire rd_setup = i_psel && !i_penable && !i_pwrite;
    wire addr_ok = (i_paddr == `CANFM_CTRL_ADDR) || (i_paddr == `CANFM_STATUS_ADDR) ||
                   (i_paddr == `CANFM_IRQ_STAT_ADDR) || (i_paddr == `CANFM_IRQ_MASK_ADDR) ||
                   (i_paddr == `CANFM_TIMEOUT_ADDR);

    assign o_pready  = 1'b1;
    assign o_pslverr = apb_acc && !addr_ok;
    assign o_prdata  = prdata_reg;

    // ****************************************
    // timeout monitors
    // ****************************************
    // low power gates the drivers, weak pulldown and pulse comparison; detection timers keep running
    wire to_short_det;
    wire to_rec;
    wire to_hvcc_det;
    wire to_hvcc_low;

    wire rec_cond = (state_reg == ST_SHORT_REC || state_reg == ST_HVCC_REC) &&
                    i_diff_recessive;

    canfm_timeout #(.WIDTH(TO_WIDTH)) u_to_short (
        .i_sys_clk  (i_sys_clk),
        .i_rst      (i_rst),
        .i_cond     (state_reg == ST_NORMAL && i_diff_dominant),
        .i_terminal (timeout_reg),
        .o_expired  (to_short_det)
    );
    canfm_timeout #(.WIDTH(TO_WIDTH)) u_to_rec (
        .i_sys_clk  (i_sys_clk),
        .i_rst      (i_rst),
        .i_cond     (rec_cond),
        .i_terminal (timeout_reg),
        .o_expired  (to_rec)
    );
    canfm_timeout #(.WIDTH(TO_WIDTH)) u_to_hvcc (
        .i_sys_clk  (i_sys_clk),
        .i_rst      (i_rst),
        .i_cond     (state_reg == ST_NORMAL && i_canh_dominant),
        .i_terminal (timeout_reg),
        .o_expired  (to_hvcc_det)
    );
    canfm_timeout #(.WIDTH(TO_WIDTH)) u_to_hlow (
        .i_sys_clk  (i_sys_clk),
        .i_rst      (i_rst),
        .i_cond     (state_reg == ST_HVCC_WAIT && i_canh_recovered),
        .i_terminal (timeout_reg),
        .o_expired  (to_hvcc_low)
    );

    // ****************************************
    // fault state machine
    // ****************************************
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_NORMAL: begin
                // mutual short checked first: it also makes canh look dominant
                if (to_short_det) begin
                    state_next = ST_SHORT;
                end else if (to_hvcc_det) begin
                    state_next = ST_HVCC;
                end
            end
            ST_SHORT: begin
                if (i_diff_recessive) begin
                    state_next = ST_SHORT_REC;
                end
            end
            ST_SHORT_REC: begin
                if (i_diff_dominant) begin
                    state_next = ST_SHORT;
                end else if (to_rec) begin
                    state_next = ST_NORMAL;
                end
            end
            ST_HVCC: begin
                if (i_canh_recovered) begin
                    state_next = ST_HVCC_WAIT;
                end
            end
            ST_HVCC_WAIT: begin
                if (!i_canh_recovered) begin
                    state_next = ST_HVCC;
                end else if (to_hvcc_low) begin
                    state_next = ST_HVCC_REC;
                end
            end
            ST_HVCC_REC: begin
                if (to_rec) begin
                    state_next = ST_NORMAL;
                end
            end
            default: begin
                state_next = ST_NORMAL;
            end
        endcase
    end

    // ****************************************
    // canl to supply pulse comparison
    // ****************************************
    wire [3:0] hcnt_inc = hcnt_reg + {3'b000, i_canh_edge};
    wire [3:0] lcnt_inc = lcnt_reg + {3'b000, i_canl_edge};
    // one extra bit so the sum cannot wrap
    wire [4:0] hcnt_ext = {1'b0, hcnt_inc};
    wire [4:0] lcnt_ext = {1'b0, lcnt_inc};
    wire [4:0] diff_ext = {1'b0, `CANFM_PULSE_DIFF};
    wire       lvcc_set = (lcnt_ext >= hcnt_ext + diff_ext) ||
                          (hcnt_ext >= lcnt_ext + diff_ext);
    wire       both_edge = i_canh_edge && i_canl_edge;

    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            hcnt_reg       <= 4'h0;
            lcnt_reg       <= 4'h0;
            match_reg      <= 4'h0;
            lvcc_fault_reg <= 1'b0;
        end else if (state_reg != ST_NORMAL || lowpwr_reg) begin
            hcnt_reg  <= 4'h0;
            lcnt_reg  <= 4'h0;
            match_reg <= 4'h0;
        end else if (both_edge) begin
            hcnt_reg <= 4'h0;
            lcnt_reg <= 4'h0;
            if (lvcc_fault_reg && match_reg + 4'h1 >= `CANFM_MATCH_COUNT) begin
                lvcc_fault_reg <= 1'b0;
                match_reg      <= 4'h0;
            end else begin
                match_reg <= match_reg + 4'h1;
            end
        end else if (i_canh_edge || i_canl_edge) begin
            match_reg <= 4'h0;
            if (lvcc_set) begin
                lvcc_fault_reg <= 1'b1;
                hcnt_reg       <= 4'h0;
                lcnt_reg       <= 4'h0;
            end else begin
                hcnt_reg <= hcnt_inc;
                lcnt_reg <= lcnt_inc;
            end
        end
    end

    // ****************************************
    // registers and state
    // ****************************************
    wire [`CANFM_EV_WIDTH-1:0] ev;
    assign ev[`CANFM_EV_SHORT_BIT] = (state_reg == ST_NORMAL) && (state_next == ST_SHORT);
    assign ev[`CANFM_EV_HVCC_BIT]  = (state_reg == ST_NORMAL) && (state_next == ST_HVCC);
    assign ev[`CANFM_EV_LVCC_BIT]  = lvcc_set && !both_edge && !lvcc_fault_reg &&
                                     (state_reg == ST_NORMAL) && !lowpwr_reg &&
                                     (i_canh_edge || i_canl_edge);
    assign ev[`CANFM_EV_CLEAR_BIT] = (state_reg != ST_NORMAL) && (state_next == ST_NORMAL);

    wire stat_rd = apb_rd && (i_paddr == `CANFM_IRQ_STAT_ADDR);

    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg    <= ST_NORMAL;
            lowpwr_reg   <= 1'b0;
            timeout_reg  <= TO_RESET;
            irq_mask_reg <= {`CANFM_EV_WIDTH{1'b0}};
            irq_stat_reg <= {`CANFM_EV_WIDTH{1'b0}};
            prdata_reg   <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            // a new event in the read cycle survives the clear
            irq_stat_reg <= (stat_rd ? {`CANFM_EV_WIDTH{1'b0}} : irq_stat_reg) | ev;
            if (apb_wr && i_paddr == `CANFM_CTRL_ADDR) begin
                lowpwr_reg <= i_pwdata[`CANFM_CTRL_LOWPWR_BIT];
            end
            if (apb_wr && i_paddr == `CANFM_IRQ_MASK_ADDR) begin
                irq_mask_reg <= i_pwdata[`CANFM_EV_WIDTH-1:0];
            end
            if (apb_wr && i_paddr == `CANFM_TIMEOUT_ADDR) begin
                timeout_reg <= i_pwdata[TO_WIDTH-1:0];
            end
            if (rd_setup) begin
                case (i_paddr)
                    `CANFM_CTRL_ADDR:     prdata_reg <= {31'h0, lowpwr_reg};
                    `CANFM_STATUS_ADDR:   prdata_reg <= {26'h0, lvcc_fault_reg, o_err_n,
                                                         1'b0, state_reg};
                    `CANFM_IRQ_STAT_ADDR: prdata_reg <= {28'h0, irq_stat_reg};
                    `CANFM_IRQ_MASK_ADDR: prdata_reg <= {28'h0, irq_mask_reg};
                    `CANFM_TIMEOUT_ADDR:  prdata_reg <= {{(32-TO_WIDTH){1'b0}}, timeout_reg};
                    default:              prdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign o_irq = |(irq_stat_reg & irq_mask_reg);

    // ****************************************
    // driver, receiver and termination outputs
    // ****************************************
    reg [1:0] rx_sel;
    reg       h_en;
    reg       l_en;
    reg       rth_on;
    reg       rtl_on;
    reg       err_n;

    always @* begin
        rx_sel = RX_DIFF;
        h_en   = 1'b1;
        l_en   = 1'b1;
        rth_on = 1'b1;
        rtl_on = 1'b1;
        err_n  = !lvcc_fault_reg; // receiver and driver untouched
        case (state_reg)
            ST_SHORT: begin
                rx_sel = RX_CANH;
                l_en   = 1'b0;
                rtl_on = 1'b0;
                err_n  = 1'b0;
            end
            ST_SHORT_REC: begin
                rx_sel = RX_CANH;
                l_en   = 1'b0;
                err_n  = 1'b0;
            end
            ST_HVCC, ST_HVCC_WAIT: begin
                rx_sel = RX_CANL;
                h_en   = 1'b0;
                rth_on = 1'b0;
                err_n  = 1'b0;
            end
            ST_HVCC_REC: begin
                rx_sel = RX_CANH;
                l_en   = 1'b0;
                err_n  = 1'b0;
            end
            default: begin
                rx_sel = RX_DIFF;
            end
        endcase
    end

    // outputs registered; drivers idle in low power while timeout detection continues
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rxd                          <= 1'b1;
            o_canh_drive                   <= 1'b0;
            o_canh_drive_en                <= 1'b0;
            o_canl_drive                   <= 1'b0;
            o_canl_drive_en                <= 1'b0;
            o_high_side_termination_switch <= 1'b1;
            o_low_side_termination_switch  <= 1'b1;
            o_rth_weak_pulldown            <= 1'b1;
            o_err_n                        <= 1'b1;
        end else begin
            case (rx_sel)
                RX_CANH: o_rxd <= i_canh_rx;
                RX_CANL: o_rxd <= i_canl_rx;
                default: o_rxd <= i_diff_rx;
            endcase
            o_canh_drive                   <= !i_txd;
            o_canl_drive                   <= !i_txd;
            o_canh_drive_en                <= h_en && !lowpwr_reg;
            o_canl_drive_en                <= l_en && !lowpwr_reg;
            o_high_side_termination_switch <= rth_on;
            o_low_side_termination_switch  <= rtl_on;
            o_rth_weak_pulldown            <= !lowpwr_reg;
            o_err_n                        <= err_n;
        end
    end
endmodule

// *** canfm_ctrl_props.sv ***
// concurrent checks on the fault mode controller ports
`timescale 1ns/1ps
module canfm_ctrl_chk (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_diff_dominant,
    input wire logic i_diff_recessive,
    input wire logic i_canh_dominant,
    input wire logic i_canh_recovered,
    input wire logic i_canh_rx,
    input wire logic i_canl_rx,
    input wire logic o_rxd,
    input wire logic o_canh_drive_en,
    input wire logic o_canl_drive_en,
    input wire logic o_high_side_termination_switch,
    input wire logic o_low_side_termination_switch,
    input wire logic o_rth_weak_pulldown,
    input wire logic o_err_n
);
    // ********
    // fault mode properties
    // ********
    wire lt = o_low_side_termination_switch;
    wire ht = o_high_side_termination_switch;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    property p_sh_in; $fell(lt) |-> $past(i_diff_dominant, 2) && $past(i_diff_dominant, 3); endproperty
    a_sh_in: assert property (p_sh_in) else $error("short entry without dominant");
    property p_sh_drv; !lt |-> !o_canl_drive_en && !o_err_n; endproperty
    a_sh_drv: assert property (p_sh_drv) else $error("canl active in short");
    property p_sh_rx; !lt |-> o_rxd == $past(i_canh_rx); endproperty
    a_sh_rx: assert property (p_sh_rx) else $error("rx not from canh");
    property p_sh_rec; $rose(lt) |-> !o_canl_drive_en && !o_err_n && $past(i_diff_recessive, 2);
    endproperty
    a_sh_rec: assert property (p_sh_rec) else $error("bad short recovery");
    property p_diff; $rose(o_err_n) && $past(o_canh_drive_en) && !$past(o_canl_drive_en) |->
        o_canl_drive_en && lt && ht && $past(i_diff_recessive, 2) && $past(i_diff_recessive, 3);
    endproperty
    a_diff: assert property (p_diff) else $error("bad return to differential");
    property p_hv_in; $fell(ht) |-> $past(i_canh_dominant, 2) && $past(i_canh_dominant, 3); endproperty
    a_hv_in: assert property (p_hv_in) else $error("canh fault without dominant");
    property p_hv_drv; !ht && o_canl_drive_en |-> !o_canh_drive_en && o_rth_weak_pulldown && !o_err_n;
    endproperty
    a_hv_drv: assert property (p_hv_drv) else $error("canh side not off");
    property p_hv_rx; !ht |-> o_rxd == $past(i_canl_rx); endproperty
    a_hv_rx: assert property (p_hv_rx) else $error("rx not from canl");
    property p_hv_rec; $rose(ht) && o_canh_drive_en |->
        !o_canl_drive_en && !o_err_n && $past(i_canh_recovered, 2); endproperty
    a_hv_rec: assert property (p_hv_rec) else $error("bad canh recovery");
endmodule

// *** can_bus_model.sv ***
// bus side model: comparator, edge and receiver levels per fault
`timescale 1ns/1ps
module can_bus_model (
    input  wire logic [1:0] i_fault,
    input  wire logic       i_lvcc,
    input  wire logic       i_pulse,
    input  wire logic       i_data,
    output wire logic       o_diff_dom,
    output wire logic       o_diff_rec,
    output wire logic       o_canh_dom,
    output wire logic       o_canh_rec,
    output wire logic       o_canh_edge,
    output wire logic       o_canl_edge,
    output wire logic       o_canh_rx,
    output wire logic       o_canl_rx,
    output wire logic       o_diff_rx
);
    // fault 1 wires shorted, 2 canh at supply
    assign o_diff_dom = (i_fault == 2'h1);
    assign o_diff_rec = (i_fault == 2'h0);
    assign o_canh_dom = (i_fault == 2'h2);
    assign o_canh_rec = (i_fault != 2'h2);
    // a faulted wire reads stuck dominant, so a wrong rx path shows 0
    assign o_canh_rx = (i_fault == 2'h2) ? 1'b0 : i_data;
    assign o_canl_rx = (i_fault == 2'h1) ? 1'b0 : i_data;
    assign o_diff_rx = (i_fault == 2'h0) ? i_data : 1'b0;
    // canl held at supply loses its pulses
    assign o_canh_edge = i_pulse;
    assign o_canl_edge = i_pulse & ~i_lvcc;
endmodule

// *** testbench.sv ***
// self-checking bench for the can fault mode controller
`timescale 1ns/1ps
`include "canfm_defs.vh"
module testbench;
    localparam int TO = 4;
    logic        i_sys_clk, i_rst, i_psel, i_penable, i_pwrite, i_txd;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, rd;
    logic [1:0]  fault;
    logic        lvcc, pulse, data, serr;
    wire  [31:0] o_prdata;
    wire         o_pready, o_pslverr, o_rxd, o_canh_drive, o_canh_drive_en, o_canl_drive;
    wire         o_canl_drive_en, o_high_side_termination_switch, o_low_side_termination_switch;
    wire         o_rth_weak_pulldown, o_err_n, o_irq;
    wire         i_diff_dominant, i_diff_recessive, i_canh_dominant, i_canh_recovered;
    wire         i_canh_edge, i_canl_edge, i_canh_rx, i_canl_rx, i_diff_rx;
    int          errors, cmp_count;
    canfm_ctrl u_dut (
        .i_sys_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
        .o_pready, .o_pslverr, .i_diff_dominant, .i_diff_recessive, .i_canh_dominant,
        .i_canh_recovered, .i_canh_edge, .i_canl_edge, .i_canh_rx, .i_canl_rx, .i_diff_rx,
        .i_txd, .o_rxd, .o_canh_drive, .o_canh_drive_en, .o_canl_drive, .o_canl_drive_en,
        .o_high_side_termination_switch, .o_low_side_termination_switch,
        .o_rth_weak_pulldown, .o_err_n, .o_irq
    );
    can_bus_model u_bus (
        .i_fault(fault), .i_lvcc(lvcc), .i_pulse(pulse), .i_data(data),
        .o_diff_dom(i_diff_dominant), .o_diff_rec(i_diff_recessive),
        .o_canh_dom(i_canh_dominant), .o_canh_rec(i_canh_recovered),
        .o_canh_edge(i_canh_edge), .o_canl_edge(i_canl_edge),
        .o_canh_rx(i_canh_rx), .o_canl_rx(i_canl_rx), .o_diff_rx(i_diff_rx)
    );
    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    // ********
    // shared tasks
    // ********
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask
    // read data and error are taken at the edge where pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        i_psel   <= 1'b1;
        i_pwrite <= wr;
        i_paddr  <= a;
        i_pwdata <= d;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        @(posedge i_sys_clk);
        while (o_pready !== 1'b1) @(posedge i_sys_clk);
        serr = o_pslverr;
        rd   = o_prdata;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            pulse <= 1'b1;
            @(posedge i_sys_clk);
            pulse <= 1'b0;
            cyc(3);
        end
    endtask
    task automatic tally_and_finish;
        $display("TB: %0d compares, %0d errors", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ********
    // scenarios
    // ********
    task automatic t_reset;
        chk({o_canh_drive_en, o_canl_drive_en, o_high_side_termination_switch,
             o_low_side_termination_switch, o_rth_weak_pulldown, o_err_n, o_irq}, 7'h7e);
        chk({o_canh_drive, o_canl_drive, o_rxd}, 3'h7);
        i_txd <= 1'b1;
        cyc(2);
        chk({o_canh_drive, o_canl_drive}, 2'h0);
        i_txd <= 1'b0;
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, `CANFM_TIMEOUT_CYCLES);
        apb(1'b0, 12'h014, 32'h0);
        chk({serr, rd}, 33'h100000000);
        apb(1'b1, 12'h010, TO);
        apb(1'b1, 12'h00c, 32'hf);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, TO);
        $display("TB: reset test done");
    endtask
    task automatic t_short;
        fault <= 2'h1;
        cyc(3);
        fault <= 2'h0;
        cyc(1);
        fault <= 2'h1;
        cyc(TO + 2);
        chk(o_err_n, 1'b1);
        cyc(2);
        chk({o_err_n, o_canl_drive_en, o_low_side_termination_switch, o_canh_drive_en}, 4'h1);
        chk({o_rxd, o_irq}, 2'h3);
        apb(1'b0, 12'h008, 32'h0);
        chk({rd[0], o_irq}, 2'h2);
        fault <= 2'h0;
        cyc(3);
        chk({o_err_n, o_canl_drive_en, o_low_side_termination_switch}, 3'h1);
        cyc(TO + 2);
        chk({o_err_n, o_canl_drive_en}, 2'h3);
        $display("TB: short test done");
    endtask
    task automatic t_hvcc;
        fault <= 2'h2;
        cyc(TO + 4);
        chk({o_canh_drive_en, o_high_side_termination_switch, o_rth_weak_pulldown,
             o_canl_drive_en, o_err_n}, 5'h6);
        chk(o_rxd, data);
        fault <= 2'h0;
        cyc(TO + 4);
        chk({o_canh_drive_en, o_high_side_termination_switch, o_canl_drive_en, o_err_n}, 4'hc);
        cyc(TO + 4);
        chk({o_canl_drive_en, o_err_n}, 2'h3);
        $display("TB: canh supply test done");
    endtask
    task automatic t_lvcc;
        apb(1'b0, 12'h008, 32'h0);
        apb(1'b1, 12'h00c, 32'h0);
        lvcc <= 1'b1;
        pulses(3);
        chk(o_err_n, 1'b1);
        pulses(1);
        cyc(2);
        chk({o_err_n, o_canh_drive_en, o_canl_drive_en, o_rxd, o_irq}, 5'he);
        apb(1'b1, 12'h00c, 32'h4);
        chk(o_irq, 1'b1);
        apb(1'b0, 12'h008, 32'h0);
        chk({rd[2], o_irq}, 2'h2);
        lvcc <= 1'b0;
        pulses(3);
        chk(o_err_n, 1'b0);
        pulses(1);
        cyc(2);
        chk(o_err_n, 1'b1);
        $display("TB: canl supply test done");
    endtask
    task automatic t_lowpwr;
        apb(1'b1, 12'h000, 32'h1);
        cyc(2);
        chk({o_canh_drive_en, o_canl_drive_en}, 2'h0);
        fault <= 2'h1;
        cyc(TO + 4);
        chk({o_err_n, o_low_side_termination_switch}, 2'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd[4], 1'b0);
        fault <= 2'h0;
        cyc(2 * TO + 8);
        apb(1'b1, 12'h000, 32'h0);
        cyc(2);
        chk({o_canh_drive_en, o_canl_drive_en, o_err_n}, 3'h7);
        $display("TB: low power test done");
    endtask
    initial begin
        i_rst = 1'b1;
        {i_psel, i_penable, i_pwrite, i_txd} = 4'h0;
        i_paddr = 12'h0;
        i_pwdata = 32'h0;
        {fault, lvcc, pulse, data} = 5'h1;
        errors = 0;
        cmp_count = 0;
        repeat (3) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        cyc(2);
        t_reset;
        t_short;
        t_hvcc;
        t_lvcc;
        t_lowpwr;
        tally_and_finish;
    end
    // the tests need well under a thousand cycles
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        errors++;
        $display("ERROR %0t: watchdog expired", $time);
        tally_and_finish;
    end
endmodule
bind canfm_ctrl canfm_ctrl_chk u_chk (
    .i_sys_clk, .i_rst, .i_diff_dominant, .i_diff_recessive, .i_canh_dominant,
    .i_canh_recovered, .i_canh_rx, .i_canl_rx, .o_rxd, .o_canh_drive_en, .o_canl_drive_en,
    .o_high_side_termination_switch, .o_low_side_termination_switch, .o_rth_weak_pulldown,
    .o_err_n
);
